/* hw/uart_cfg.svh */
// constants of the second serial port: offsets, fields, codes, timing
// assumes byte addressing on a 32-bit wishbone bus, one word per register
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// register byte offsets
`define A_DATA    8'h00
`define A_CS      8'h04
`define A_FMT     8'h08
`define A_BCON    8'h0c
`define A_RLH     8'h10
`define A_RLL     8'h14
// serial_control_status bits
`define CS_RI     0
`define CS_TI     1
`define CS_OVF    2
`define CS_PERR   3
`define CS_REN    4
`define CS_RX9    5
`define CS_TX9    6
`define CS_IE     7
`define CS_WMASK  8'hd0
// serial_format_select bits
`define FM_LEN    0
`define FM_PE     2
`define FM_PT     3
`define FM_SL     5
`define FM_XBE    6
`define FM_MASK   8'h7f
// baud_gen_control bits
`define BC_PS     0
`define BC_EN     6
`define BC_MASK   8'h43
// prescaler select codes and divisors
`define PS_SEL12  2'h0
`define PS_SEL4   2'h1
`define PS_SEL48  2'h2
`define PS_DIV1   6'h01
`define PS_DIV4   6'h04
`define PS_DIV12  6'h0c
`define PS_DIV48  6'h30
// parity kinds
`define PT_ODD    2'h0
`define PT_EVEN   2'h1
`define PT_MARK   2'h2
// data length and stop length in half bit times
`define FULL_BYTE 8'hff
`define LEN_MAX   2'h3
`define STOP_S    3'h2
`define STOP_L    3'h4
`define STOP_L5   3'h3
`define STOP_LAST 3'h1
// reset values and line levels
`define RST_REG   8'h00
`define LINE_IDLE 1'b1
`endif

/* hw/uart_pkg.sv */
// types shared by the second serial port
// assumes nothing beyond a systemverilog elaborator
`default_nettype none
package uart_pkg;
   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
   } rx_state_t;
endpackage
`default_nettype wire

/* hw/baud_gen.sv */
// baud timer: prescaler feeding a 16-bit up-counter with auto reload
// assumes the core clock only; restart_i realigns the phase to an edge
`default_nettype none
`include "uart_cfg.svh"
module baud_gen #(
   parameter int TW = 16
) (
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // control
   input  wire logic          en_i,
   input  wire logic          restart_i,
   input  wire logic [1:0]    ps_sel_i,
   input  wire logic [TW-1:0] reload_i,
   // one pulse per timer overflow, half a bit time
   output logic               ovf_o
);
   if (TW < 2) begin : g_chk
      $error("baud_gen: timer too narrow");
   end

   logic [5:0]    ps_q;
   logic [TW-1:0] tmr_q;
   wire  [5:0]    ps_div = (ps_sel_i == `PS_SEL12) ? `PS_DIV12 :
                           (ps_sel_i == `PS_SEL4)  ? `PS_DIV4  :
                           (ps_sel_i == `PS_SEL48) ? `PS_DIV48 :
                                                     `PS_DIV1;
   // >= so a divisor change mid count cannot run away
   wire           tick   = (ps_q >= ps_div - `PS_DIV1);
   wire           wrap   = tick && (&tmr_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ps_q  <= '0;
         tmr_q <= '0;
         ovf_o <= 1'b0;
      end else if (!en_i || restart_i) begin
         ps_q  <= '0;
         tmr_q <= reload_i;
         ovf_o <= 1'b0;
      end else begin
         ps_q  <= tick ? '0 : ps_q + 6'h01;
         if (tick) begin
            tmr_q <= wrap ? reload_i : tmr_q + 1'b1;
         end
         ovf_o <= wrap;
      end
   end

   reload_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wrap && en_i && !restart_i |=> tmr_q == $past(reload_i))
      else $error("timer not reloaded after wrap");
   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && !wrap && en_i && !restart_i |=> tmr_q == $past(tmr_q) + 1'b1)
      else $error("timer did not step on tick");
endmodule
`default_nettype wire

/* hw/rx_fifo.sv */
// receive fifo: entry 0 is the oldest byte and is itself a register
// drops pushes while full unless a pop frees a slot; assumes the owner reports the loss
`default_nettype none
module rx_fifo #(
   parameter int DW    = 9,
   parameter int DEPTH = 3
) (
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // fill side
   input  wire logic          push_i,
   input  wire logic [DW-1:0] din_i,
   // drain side
   input  wire logic          pop_i,
   output logic [DW-1:0]      head_o,
   output logic               empty_o,
   output logic               full_o
);
   localparam int CW = $clog2(DEPTH + 1);
   if (DEPTH < 2 || DW < 1) begin : g_chk
      $error("rx_fifo: unsupported shape");
   end

   logic [DW-1:0] ent_q [DEPTH];
   logic [CW-1:0] cnt_q;
   wire           do_pop  = pop_i && !empty_o;
   wire           do_push = push_i && (!full_o || do_pop);
   wire  [CW-1:0] slot    = do_pop ? cnt_q - CW'(1) : cnt_q;

   assign empty_o = (cnt_q == '0);
   assign full_o  = (cnt_q == CW'(DEPTH));
   assign head_o  = ent_q[0];

   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      logic [DW-1:0] nxt;
      if (i + 1 < DEPTH) begin : g_mid
         assign nxt = ent_q[i+1];
      end else begin : g_end
         assign nxt = ent_q[i];
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ent_q[i] <= '0;
         end else if (do_push && slot == CW'(i)) begin
            ent_q[i] <= din_i;
         end else if (do_pop) begin
            ent_q[i] <= nxt;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
   end

   pop_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
      do_pop && !do_push && cnt_q > CW'(1) |=> head_o == $past(ent_q[1]))
      else $error("fifo head not advanced on pop");
endmodule
`default_nettype wire

/* hw/second_serial_port.sv */
// second serial port: wishbone registers, tx/rx framing, 3-byte rx fifo
// assumes classic wishbone on clk_i and rx_i already synchronous to clk_i
//
// Our own choices: register access over Wishbone and the placing of the registers.
`default_nettype none
`include "uart_cfg.svh"
// How it works
// - full duplex, tx and rx independent, asynchronous
// - data window write loads transmit holding register
// - data window read gives oldest fifo byte
// - fifo holds three; extra byte lost, overflow
// - enabled interrupt on tx done or rx ready
// - flags stay until software clears them
// - rx ready clear ignored while fifo nonempty
// - dedicated 16-bit timers on core clock, one for tx and one for rx
// - enable bit, prescale 1, 4, 12, 48
// - generator disabled halts all serial activity
// - high and low bytes form reload
// - timer increments each prescaled tick from reload
// - timer wrap reloads, giving periodic overflow
// - bit time is two overflows
// - start low, data lsb first, extra, stop high
// - data length five to eight bits
// - even odd mark space parity, else extra bit
module second_serial_port
   import uart_pkg::*;
#(
   parameter int FIFO_DEPTH = 3
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // serial line
   input  wire logic        rx_i,
   output logic             tx_o,
   // interrupt request
   output logic             irq_o
);
   if (FIFO_DEPTH < 2) begin : g_chk
      $error("second_serial_port: fifo too shallow");
   end

   function automatic logic par_of(input logic [7:0] d,
                                   input logic [1:0] len,
                                   input logic [1:0] pt);
      logic p;
      p = ^(d & (`FULL_BYTE >> (`LEN_MAX - len)));
      case (pt)
         `PT_ODD:  par_of = !p;
         `PT_EVEN: par_of = p;
         `PT_MARK: par_of = 1'b1;
         default:  par_of = 1'b0;
      endcase
   endfunction

   logic        ack_q;
   logic [31:0] dat_q;
   logic [7:0]  cs_q;
   logic [7:0]  fmt_q;
   logic [7:0]  bcon_q;
   logic [7:0]  rlh_q;
   logic [7:0]  rll_q;
   logic [7:0]  thr_q;
   logic        thr_full_q;
   logic        ri_q;
   logic        ti_q;
   logic        ovf_q;
   logic        perr_q;
   logic        irq_q;
   tx_state_t   tx_st_q;
   logic [7:0]  tx_sh_q;
   logic [2:0]  tx_cnt_q;
   logic [2:0]  tx_stop_q;
   logic        tx_half_q;
   logic        tx_x_q;
   logic        tx_q;
   rx_state_t   rx_st_q;
   logic [7:0]  rx_sh_q;
   logic [2:0]  rx_cnt_q;
   logic        rx_half_q;
   logic        rx_x_q;
   logic        rx_prev_q;
   logic [8:0]  head;
   logic        fifo_empty;
   logic        fifo_full;
   logic        tx_ovf;
   logic        rx_ovf;
   logic [7:0]  cs_rd;

   // bus decode
   wire        acc      = wb_cyc_i && wb_stb_i && !ack_q;
   wire        wr       = acc && wb_we_i && wb_sel_i[0];
   wire        rd       = acc && !wb_we_i;
   wire [7:0]  adr      = {wb_adr_i[7:2], 2'b00};
   wire        hit_dat  = (adr == `A_DATA);
   wire        hit_cs   = (adr == `A_CS);
   wire        hit_fmt  = (adr == `A_FMT);
   wire        hit_bcon = (adr == `A_BCON);
   wire        hit_rlh  = (adr == `A_RLH);
   wire        hit_rll  = (adr == `A_RLL);
   wire [7:0]  wbyte    = wb_dat_i[7:0];
   wire        pop      = rd && hit_dat;
   wire        clr_cs   = wr && hit_cs;
   wire [7:0]  rdata    = hit_dat  ? head[7:0] :
                          hit_cs   ? cs_rd     :
                          hit_fmt  ? fmt_q     :
                          hit_bcon ? bcon_q    :
                          hit_rlh  ? rlh_q     :
                          hit_rll  ? rll_q     : `RST_REG;

   // frame format
   wire        bg_en    = bcon_q[`BC_EN];
   wire [1:0]  len      = fmt_q[`FM_LEN +: 2];
   wire [1:0]  pt       = fmt_q[`FM_PT +: 2];
   wire        pe       = fmt_q[`FM_PE];
   wire        has_x    = pe || fmt_q[`FM_XBE];
   wire [2:0]  last     = {1'b1, len};
   // long stop is 1.5 bits for 5-bit data, else 2 bits
   wire [2:0]  stop_h   = !fmt_q[`FM_SL] ? `STOP_S :
                          (len == '0)    ? `STOP_L5 : `STOP_L;

   // transmit and receive events
   wire        tx_go    = tx_st_q == TX_IDLE && thr_full_q && bg_en;
   wire        tx_end   = tx_st_q == TX_STOP && tx_ovf &&
                          tx_stop_q == `STOP_LAST;
   wire        rx_go    = rx_st_q == RX_IDLE && cs_q[`CS_REN] && bg_en &&
                          rx_prev_q && !rx_i;
   wire        rx_done  = rx_st_q == RX_STOP && rx_ovf && rx_half_q;
   wire        rx_lost  = rx_done && fifo_full && !pop;
   wire        rx_perr  = rx_done && pe && (rx_x_q != par_of(rx_sh_q, len, pt));
   wire [8:0]  rx_word  = {has_x ? rx_x_q : rx_i, rx_sh_q};

   // flag next values; a hardware set wins over a software clear
   wire        ti_d     = tx_end || (ti_q && !(clr_cs && !wbyte[`CS_TI]));
   wire        ri_d     = (rx_done && !rx_lost) ||
                          (ri_q && !(clr_cs && !wbyte[`CS_RI] && fifo_empty));
   wire        ovf_d    = rx_lost || (ovf_q && !(clr_cs && !wbyte[`CS_OVF]));
   wire        perr_d   = rx_perr || (perr_q && !(clr_cs && !wbyte[`CS_PERR]));
   wire        thr_d    = (wr && hit_dat) || (thr_full_q && !tx_go);

   always_comb begin
      cs_rd           = cs_q;
      cs_rd[`CS_RI]   = ri_q;
      cs_rd[`CS_TI]   = ti_q;
      cs_rd[`CS_OVF]  = ovf_q;
      cs_rd[`CS_PERR] = perr_q;
      cs_rd[`CS_RX9]  = head[8];
   end

   // separate timers so a receive edge can realign without disturbing tx
   baud_gen u_tx_baud (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .en_i      (bg_en),
      .restart_i (tx_go),
      .ps_sel_i  (bcon_q[`BC_PS +: 2]),
      .reload_i  ({rlh_q, rll_q}),
      .ovf_o     (tx_ovf)
   );
   baud_gen u_rx_baud (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .en_i      (bg_en),
      .restart_i (rx_go),
      .ps_sel_i  (bcon_q[`BC_PS +: 2]),
      .reload_i  ({rlh_q, rll_q}),
      .ovf_o     (rx_ovf)
   );
   rx_fifo #(
      .DW    (9),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .push_i  (rx_done),
      .din_i   (rx_word),
      .pop_i   (pop),
      .head_o  (head),
      .empty_o (fifo_empty),
      .full_o  (fifo_full)
   );

   // software registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_q   <= `RST_REG;
         fmt_q  <= `RST_REG;
         bcon_q <= `RST_REG;
         rlh_q  <= `RST_REG;
         rll_q  <= `RST_REG;
         thr_q  <= `RST_REG;
      end else if (wr) begin
         if (hit_cs)   cs_q   <= wbyte & `CS_WMASK;
         if (hit_fmt)  fmt_q  <= wbyte & `FM_MASK;
         if (hit_bcon) bcon_q <= wbyte & `BC_MASK;
         if (hit_rlh)  rlh_q  <= wbyte;
         if (hit_rll)  rll_q  <= wbyte;
         if (hit_dat)  thr_q  <= wbyte;
      end
   end

   // bus answer: one wait state, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= acc;
         dat_q <= rd ? 32'(rdata) : '0;
      end
   end

   // flags and interrupt request; nothing but software clears them, except thr_full_q, which tx_go clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ti_q       <= 1'b0;
         ri_q       <= 1'b0;
         ovf_q      <= 1'b0;
         perr_q     <= 1'b0;
         thr_full_q <= 1'b0;
         irq_q      <= 1'b0;
         rx_prev_q  <= `LINE_IDLE;
      end else begin
         ti_q       <= ti_d;
         ri_q       <= ri_d;
         ovf_q      <= ovf_d;
         perr_q     <= perr_d;
         thr_full_q <= thr_d;
         irq_q      <= cs_q[`CS_IE] && (ti_q || ri_q);
         rx_prev_q  <= rx_i;
      end
   end

   // transmitter; every half bit is one timer overflow
   always_ff @(posedge clk_i) begin
      if (rst_i || !bg_en) begin
         tx_st_q   <= TX_IDLE;
         tx_sh_q   <= '0;
         tx_cnt_q  <= '0;
         tx_stop_q <= '0;
         tx_half_q <= 1'b0;
         tx_x_q    <= 1'b0;
         tx_q      <= `LINE_IDLE;
      end else if (tx_go) begin
         tx_st_q   <= TX_START;
         tx_sh_q   <= thr_q;
         tx_x_q    <= pe ? par_of(thr_q, len, pt) : cs_q[`CS_TX9];
         tx_half_q <= 1'b0;
         tx_q      <= !`LINE_IDLE;
      end else if (tx_ovf) begin
         tx_half_q <= !tx_half_q;
         case (tx_st_q)
            TX_START: if (tx_half_q) begin
               tx_st_q  <= TX_DATA;
               tx_q     <= tx_sh_q[0];
               tx_sh_q  <= tx_sh_q >> 1;
               tx_cnt_q <= '0;
            end
            TX_DATA: if (tx_half_q) begin
               if (tx_cnt_q == last) begin
                  tx_st_q   <= has_x ? TX_PAR : TX_STOP;
                  tx_q      <= has_x ? tx_x_q : `LINE_IDLE;
                  tx_stop_q <= stop_h;
               end else begin
                  tx_q     <= tx_sh_q[0];
                  tx_sh_q  <= tx_sh_q >> 1;
                  tx_cnt_q <= tx_cnt_q + 3'h1;
               end
            end
            TX_PAR: if (tx_half_q) begin
               tx_st_q   <= TX_STOP;
               tx_q      <= `LINE_IDLE;
               tx_stop_q <= stop_h;
            end
            TX_STOP: begin
               tx_stop_q <= tx_stop_q - 3'h1;
               if (tx_end) tx_st_q <= TX_IDLE;
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // receiver; its timer restarts on the start edge so samples land mid bit
   always_ff @(posedge clk_i) begin
      if (rst_i || !bg_en) begin
         rx_st_q   <= RX_IDLE;
         rx_sh_q   <= '0;
         rx_cnt_q  <= '0;
         rx_half_q <= 1'b0;
         rx_x_q    <= 1'b0;
      end else if (rx_go) begin
         rx_st_q   <= RX_START;
         rx_half_q <= 1'b0;
      end else if (rx_ovf) begin
         rx_half_q <= !rx_half_q;
         case (rx_st_q)
            RX_START: begin
               // a start bit gone high by mid bit was a glitch
               rx_half_q <= 1'b0;
               rx_sh_q   <= '0;
               rx_cnt_q  <= '0;
               rx_st_q   <= rx_i ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_half_q) begin
               rx_sh_q[rx_cnt_q] <= rx_i;
               rx_cnt_q          <= rx_cnt_q + 3'h1;
               if (rx_cnt_q == last) begin
                  rx_st_q <= has_x ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: if (rx_half_q) begin
               rx_x_q  <= rx_i;
               rx_st_q <= RX_STOP;
            end
            RX_STOP: if (rx_half_q) rx_st_q <= RX_IDLE;
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign tx_o     = tx_q;
   assign irq_o    = irq_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   thr_load_a: assert property (
      wr && hit_dat |=> thr_full_q && thr_q == $past(wbyte))
      else $error("data write did not load holding register");
   data_read_a: assert property (
      pop |=> wb_ack_o && wb_dat_o[7:0] == $past(head[7:0]))
      else $error("data read did not return fifo head");
   fifo_over_a: assert property (
      rx_done && fifo_full && !pop |=> ovf_q && ri_q == $past(ri_q))
      else $error("overflow not recorded");
   irq_req_a: assert property (
      cs_q[`CS_IE] && (ti_q || ri_q) |=> irq_o)
      else $error("interrupt not requested");
   ri_hold_a: assert property (
      clr_cs && !wbyte[`CS_RI] && ri_q && !fifo_empty |=> ri_q)
      else $error("rx ready cleared with bytes left");
   baud_off_a: assert property (
      !bg_en |=> tx_st_q == TX_IDLE && rx_st_q == RX_IDLE && tx_o)
      else $error("serial activity with generator off");
   start_low_a: assert property (
      tx_go ##1 bg_en |-> !tx_o)
      else $error("start bit not low");
   done_stop_a: assert property (
      $rose(ti_q) |-> $past(tx_st_q) == TX_STOP && $past(tx_ovf))
      else $error("tx done outside stop end");
endmodule
`default_nettype wire

/* dv/serial_node.sv */
// remote serial node: sends and captures frames of 8 data bits, 1 stop
// assumes bit time in core clock cycles on bit_cyc_i, line idles high
`default_nettype none
module serial_node (
   // clock and timing
   input  wire logic        clk_i,
   input  wire logic [15:0] bit_cyc_i,
   // serial line
   input  wire logic        line_i,
   output logic             line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];
   int         stop_bad;
   initial begin
      line_o = 1'b1;
      stop_bad = 0;
   end
   // frames go out back to back; the line stays high between them
   task automatic send(input logic [7:0] b);
      for (int i = -1; i < 9; i++) begin
         @(posedge clk_i);
         line_o <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
         repeat (bit_cyc_i - 1) @(posedge clk_i);
      end
   endtask
   // sampled mid bit on the falling clock, clear of the design's edge
   always begin : capture
      logic [7:0] b;
      @(negedge line_i);
      repeat (bit_cyc_i / 2) @(negedge clk_i);
      for (int i = 0; i < 9; i++) begin
         repeat (bit_cyc_i) @(negedge clk_i);
         if (i < 8) b[i] = line_i;
         else if (line_i !== 1'b1) stop_bad++;
      end
      got_q.push_back(b);
   end
endmodule
`default_nettype wire

/* dv/second_serial_port_tb_top.sv */
// testbench of the second serial port against a remote serial node
// assumes the design's wishbone answers within a few cycles
`default_nettype none
`include "uart_cfg.svh"
module second_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        rx;
   logic        tx;
   logic        irq;
   logic [15:0] bit_cyc;
   logic [31:0] rd;
   int          bad_count;
   int          checks_done;

   second_serial_port dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_i(rx), .tx_o(tx),
      .irq_o(irq)
   );
   serial_node node_u (
      .clk_i(clk_i), .bit_cyc_i(bit_cyc), .line_i(tx), .line_o(rx)
   );

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic stall;
      bad_count++;
      $display("[ERR] wait exp done got timeout");
      tally_and_finish();
   endtask
   task automatic chk_byte(input string n, input logic [7:0] e,
                           input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
   endtask
   // even parity over seven data bits: the bit that makes the ones even
   function automatic logic even_par(input logic [7:0] d);
      return ^d[6:0];
   endfunction
   // ack and read data are taken at the rising edge that sees ack high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
         if (n > 20) stall();
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_rx(input int k);
      int n;
      n = 0;
      while (node_u.got_q.size() < k) begin
         @(negedge clk_i);
         n++;
         if (n > 5000) stall();
      end
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin : main
      logic [1:0] ps_t[4];
      logic [7:0] rl_t[4];
      int         bt[4];
      logic [7:0] b[4];
      logic       low;
      int         cnt;
      ps_t = '{2'h2, 2'h0, 2'h1, 2'h3};
      rl_t = '{8'hff, 8'hff, 8'hfe, 8'hf8};
      bt = '{96, 24, 16, 16};
      {cyc, stb, we, adr, wdat} = '0;
      bad_count = 0;
      checks_done = 0;
      bit_cyc = 16'h0060;
      rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      void'($urandom(32'hfbf97138));
      wb(1'b0, `A_CS, 8'h00);
      chk_byte("cs reset", `RST_REG, rd[7:0]);
      wb(1'b0, `A_BCON, 8'h00);
      chk_byte("bcon reset", `RST_REG, rd[7:0]);
      wb(1'b0, 8'h18, 8'h00);
      chk_byte("unmapped", 8'h00, rd[7:0]);
      chk_bit("tx idle", `LINE_IDLE, tx);
      $display("test reset done");
      wb(1'b1, `A_FMT, 8'h03);
      wb(1'b1, `A_CS, 8'h90);
      // every prescaler; bit times stay at or below clock over sixteen
      for (int k = 0; k < 4; k++) begin
         bit_cyc <= 16'(bt[k]);
         wb(1'b1, `A_RLH, 8'hff);
         wb(1'b1, `A_RLL, rl_t[k]);
         wb(1'b1, `A_BCON, {6'h10, ps_t[k]});
         b[0] = 8'($urandom) | 8'h01;
         wb(1'b1, `A_DATA, b[0]);
         cnt = 0;
         while (tx !== 1'b0) begin
            @(negedge clk_i);
            cnt++;
            if (cnt > 200) stall();
         end
         cnt = 0;
         while (tx === 1'b0) begin
            @(negedge clk_i);
            cnt++;
            if (cnt > 200) stall();
         end
         // start bit carries the timer's one cycle restart latency
         chk_byte("start width", 8'(bt[k] + 1), 8'(cnt));
         wait_rx(k + 1);
         repeat (bt[k]) @(negedge clk_i);
         chk_byte("tx byte", b[0], node_u.got_q[k]);
         wb(1'b0, `A_CS, 8'h00);
         chk_byte("tx done", 8'h02, rd[7:0] & 8'h07);
         chk_bit("irq tx", 1'b1, irq);
         wb(1'b1, `A_CS, 8'h90);
         wb(1'b0, `A_CS, 8'h00);
         chk_byte("tx clear", 8'h00, rd[7:0] & 8'h07);
         chk_bit("irq off", 1'b0, irq);
      end
      $display("test rates done");
      for (int k = 0; k < 4; k++) begin
         b[k] = 8'($urandom);
         node_u.send(b[k]);
      end
      wb(1'b0, `A_CS, 8'h00);
      chk_byte("overflow", 8'h15, rd[7:0] & 8'h1f);
      chk_bit("irq rx", 1'b1, irq);
      wb(1'b0, `A_DATA, 8'h00);
      chk_byte("pop first", b[0], rd[7:0]);
      wb(1'b1, `A_CS, 8'h90);
      wb(1'b0, `A_CS, 8'h00);
      chk_byte("rx held", 8'h01, rd[7:0] & 8'h07);
      for (int k = 1; k < 3; k++) begin
         wb(1'b0, `A_DATA, 8'h00);
         chk_byte("pop next", b[k], rd[7:0]);
      end
      wb(1'b1, `A_CS, 8'h90);
      wb(1'b0, `A_CS, 8'h00);
      chk_byte("rx clear", 8'h00, rd[7:0] & 8'h07);
      $display("test fifo done");
      b[0] = 8'($urandom);
      b[1] = 8'($urandom);
      fork
         node_u.send(b[0]);
         wb(1'b1, `A_DATA, b[1]);
      join
      wait_rx(5);
      repeat (16) @(negedge clk_i);
      chk_byte("duplex tx", b[1], node_u.got_q[4]);
      wb(1'b0, `A_DATA, 8'h00);
      chk_byte("duplex rx", b[0], rd[7:0]);
      chk_byte("stop bits", 8'h00, 8'(node_u.stop_bad));
      $display("test duplex done");
      // seven data bits and even parity fill the node's ten bit frame
      wb(1'b1, `A_FMT, 8'h0e);
      for (int k = 0; k < 2; k++) begin
         b[0] = 8'($urandom) & 8'h7f;
         b[1] = {even_par(b[0]) ^ 1'(k), b[0][6:0]};
         b[2] = {even_par(b[0]), b[0][6:0]};
         fork
            node_u.send(b[1]);
            wb(1'b1, `A_DATA, b[0]);
         join
         wait_rx(6 + k);
         repeat (16) @(negedge clk_i);
         chk_byte("parity tx", b[2], node_u.got_q[5 + k]);
         wb(1'b0, `A_CS, 8'h00);
         chk_bit("parity err", 1'(k), rd[`CS_PERR]);
         chk_bit("rx ninth", b[1][7], rd[`CS_RX9]);
         wb(1'b0, `A_DATA, 8'h00);
         chk_byte("parity rx", b[0], rd[7:0]);
         wb(1'b1, `A_CS, 8'h90);
      end
      $display("test parity done");
      wb(1'b1, `A_CS, 8'h90);
      wb(1'b1, `A_BCON, 8'h03);
      wb(1'b1, `A_DATA, 8'h5a);
      low = 1'b0;
      fork
         node_u.send(8'h3c);
         repeat (200) begin
            @(negedge clk_i);
            if (tx !== 1'b1) low = 1'b1;
         end
      join
      chk_bit("tx halted", 1'b0, low);
      wb(1'b0, `A_CS, 8'h00);
      chk_byte("rx halted", 8'h10, rd[7:0] & 8'h1f);
      $display("test halt done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
